/* File: logic/byte_bank.sv */
// Bank of byte registers written by index, with hardware set bits.
// Assumes one write per cycle; set bits win over a write clearing them.
`default_nettype none

module byte_bank #(
	parameter int DEPTH = 8,
	parameter int IDX_W = 3
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Host write
	input wire logic wr_en,
	input wire logic [IDX_W-1:0] wr_idx,
	input wire logic [7:0] wr_data,
	// Hardware set and contents
	input wire logic [DEPTH*8-1:0] set_bits,
	output logic [DEPTH*8-1:0] flat
);

	genvar i;
	generate
		for (i = 0; i < DEPTH; i++)
		begin : g_byte
			logic [7:0] byte_reg;
			wire hit = wr_en && (wr_idx == IDX_W'(i));
			wire [7:0] byte_next = (hit ? wr_data : byte_reg) | set_bits[i*8 +: 8];
			always_ff @(posedge clk or posedge rst)
			begin
				if (rst)
					byte_reg <= 8'h00;
				else
					byte_reg <= byte_next;
			end
			assign flat[i*8 +: 8] = byte_reg;
		end
	endgenerate

endmodule : byte_bank

`default_nettype wire

/* File: logic/host_map_defines.svh */
// Offsets and layout constants of the byte-wide host register map.
// Assumes a 9-bit byte address with the low data byte at the even offset.
`ifndef HOST_MAP_DEFINES_SVH
`define HOST_MAP_DEFINES_SVH

`define ADDR_W 9
`define OFS_CMD_LOW 9'h000
`define OFS_CMD_HIGH 9'h001
`define OFS_INT_LOW 9'h002
`define OFS_INT_HIGH 9'h003
`define OFS_IO_LOW 9'h004
`define OFS_IO_HIGH 9'h005
`define OFS_FIFO_LOW 9'h006
`define OFS_FIFO_HIGH 9'h007
`define OFS_GAP_FIRST 9'h008
`define OFS_GAP_LAST 9'h077
`define OFS_NODE_FIRST 9'h078
`define OFS_NODE_LAST 9'h0b7
`define OFS_ERR_FIRST 9'h0b8
`define OFS_ERR_LAST 9'h0bf
`define OFS_SET_FIRST 9'h0c0
`define OFS_SET_LAST 9'h0df
`define OFS_FLAG_FIRST 9'h0e0
`define OFS_FLAG_LAST 9'h0ff
`define OFS_PORT_FIRST 9'h100
`define OFS_PORT_LAST 9'h1ff
`define GAP_READ_VALUE 8'h00
`define STAGE_RESET 8'h00
`define WORD_RESET 16'h0000

`endif

/* File: logic/host_map_pkg.sv */
// Types and the shared address decoder of the byte-wide host register map.
// Assumes host_map_defines.svh for every offset.
`include "host_map_defines.svh"
`default_nettype none

package host_map_pkg;

	typedef enum logic [3:0] {
		REGION_CMD,
		REGION_INT,
		REGION_IO,
		REGION_FIFO,
		REGION_GAP,
		REGION_NODE,
		REGION_ERR,
		REGION_SET,
		REGION_FLAG,
		REGION_PORT
	} region_t;

	function automatic region_t region_of(input logic [8:0] a);
		if (a <= `OFS_CMD_HIGH)
			return REGION_CMD;
		else if (a <= `OFS_INT_HIGH)
			return REGION_INT;
		else if (a <= `OFS_IO_HIGH)
			return REGION_IO;
		else if (a <= `OFS_FIFO_HIGH)
			return REGION_FIFO;
		else if (a <= `OFS_GAP_LAST)
			return REGION_GAP;
		else if (a <= `OFS_NODE_LAST)
			return REGION_NODE;
		else if (a <= `OFS_ERR_LAST)
			return REGION_ERR;
		else if (a <= `OFS_SET_LAST)
			return REGION_SET;
		else if (a <= `OFS_FLAG_LAST)
			return REGION_FLAG;
		else
			return REGION_PORT;
	endfunction : region_of

endpackage : host_map_pkg

`default_nettype wire

/* File: logic/host_register_map.sv */
// Byte-wide host register map of the serial network center controller.
// Assumes host strobes synchronous to clk and the core behind the word ports.
`include "host_map_defines.svh"
`default_nettype none

module host_register_map
	import host_map_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Mode straps
	input wire logic host_mode_select_bit0,
	input wire logic host_mode_select_bit1,
	// Host bus
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [8:0] addr,
	input wire logic [7:0] wdata_in,
	output logic [7:0] rdata_out,
	output logic data_oe_n,
	output logic command_handshake_out,
	// Command and status
	output logic [15:0] command_word,
	output logic command_valid,
	input wire logic command_done,
	input wire logic [15:0] status_word,
	input wire logic [15:0] interrupt_status,
	// Input/output buffer
	output logic [15:0] io_buffer,
	input wire logic io_load,
	input wire logic [15:0] io_load_data,
	// Transmit and receive data
	output logic [15:0] tx_data,
	output logic tx_push,
	input wire logic tx_ready,
	input wire logic [15:0] rx_data,
	input wire logic rx_valid,
	output logic rx_pop,
	// Per-node areas
	output logic [511:0] node_info,
	input wire logic [63:0] cyclic_error_set,
	output logic [63:0] cyclic_error_flags,
	output logic [255:0] input_change_settings,
	input wire logic [255:0] input_change_set,
	output logic [255:0] input_change_flags,
	output logic [2047:0] port_data
);

	// Only the 8-bit mode answers; other strap settings leave the bus idle
	wire mode_ok = host_mode_select_bit0 && host_mode_select_bit1;
	wire rd_act = mode_ok && !cs_n && !rd_n;
	wire wr_act = mode_ok && !cs_n && !wr_n;

	logic rd_seen_reg;
	logic wr_seen_reg;
	// One action per strobe, however long the host holds it
	wire rd_start = rd_act && !rd_seen_reg;
	wire wr_start = wr_act && !wr_seen_reg;

	wire region_t region = region_of(addr);
	wire high_byte = addr[0];

	wire [8:0] node_off = addr - `OFS_NODE_FIRST;
	wire [8:0] err_off = addr - `OFS_ERR_FIRST;
	wire [8:0] set_off = addr - `OFS_SET_FIRST;
	wire [8:0] flag_off = addr - `OFS_FLAG_FIRST;
	wire [8:0] port_off = addr - `OFS_PORT_FIRST;
	wire [5:0] node_idx = node_off[5:0];
	wire [2:0] err_idx = err_off[2:0];
	wire [4:0] set_idx = set_off[4:0];
	wire [4:0] flag_idx = flag_off[4:0];
	wire [7:0] port_idx = port_off[7:0];

	wire wr_cmd = wr_start && (region == REGION_CMD);
	wire wr_io = wr_start && (region == REGION_IO);
	wire wr_fifo = wr_start && (region == REGION_FIFO);
	wire wr_node = wr_start && (region == REGION_NODE);
	wire wr_err = wr_start && (region == REGION_ERR);
	wire wr_set = wr_start && (region == REGION_SET);
	wire wr_flag = wr_start && (region == REGION_FLAG);
	wire wr_port = wr_start && (region == REGION_PORT);
	// Interrupt status and gap writes reach no enable at all

	// Low write byte waits here so the word never changes half-done
	logic [7:0] stage_reg;
	wire stage_load = (wr_cmd || wr_io || wr_fifo) && !high_byte;
	wire [7:0] stage_next = stage_load ? wdata_in : stage_reg;
	wire [15:0] staged_word = {wdata_in, stage_reg};

	wire cmd_commit = wr_cmd && high_byte;
	wire io_commit = wr_io && high_byte;
	// A push with the core not ready is dropped; the host polls status first
	wire tx_commit = wr_fifo && high_byte && tx_ready;

	logic [15:0] command_reg;
	logic command_valid_reg;
	logic [15:0] io_buffer_reg;
	logic [15:0] tx_data_reg;
	logic tx_push_reg;
	logic busy_reg;

	wire [15:0] command_next = cmd_commit ? staged_word : command_reg;
	wire [15:0] tx_data_next = tx_commit ? staged_word : tx_data_reg;
	// Host commit outranks a core load in the same cycle
	wire [15:0] io_next = io_commit ? staged_word : (io_load ? io_load_data : io_buffer_reg);
	// A new command in the done cycle keeps the handshake low
	wire busy_next = cmd_commit || (busy_reg && !command_done);

	// Low read takes the whole word; the high read returns the copy
	logic [15:0] hold_reg;

	// Regions the host reaches as two-byte words
	function automatic logic is_word(input region_t r);
		return r == REGION_CMD || r == REGION_INT || r == REGION_IO || r == REGION_FIFO;
	endfunction : is_word
	wire rd_word = rd_start && !high_byte && is_word(region);
	wire rd_fifo_low = rd_start && !high_byte && (region == REGION_FIFO);
	assign rx_pop = rd_fifo_low && rx_valid;
	// An empty receive side reads as zero and pops nothing
	wire [15:0] rx_word = rx_valid ? rx_data : `WORD_RESET;
	wire [15:0] word_live = (region == REGION_CMD) ? status_word :
		(region == REGION_INT) ? interrupt_status :
		(region == REGION_IO) ? io_buffer_reg : rx_word;
	wire [15:0] hold_next = rd_word ? word_live : hold_reg;

	wire [7:0] word_byte = high_byte ? hold_reg[15:8] : word_live[7:0];
	wire [7:0] node_byte = node_info[node_idx*8 +: 8];
	wire [7:0] err_byte = cyclic_error_flags[err_idx*8 +: 8];
	wire [7:0] set_byte = input_change_settings[set_idx*8 +: 8];
	wire [7:0] flag_byte = input_change_flags[flag_idx*8 +: 8];
	wire [7:0] port_byte = port_data[port_idx*8 +: 8];

	logic [7:0] read_byte;
	always_comb
	begin
		case (region)
			REGION_CMD, REGION_INT, REGION_IO, REGION_FIFO:
				read_byte = word_byte;
			REGION_NODE:
				read_byte = node_byte;
			REGION_ERR:
				read_byte = err_byte;
			REGION_SET:
				read_byte = set_byte;
			REGION_FLAG:
				read_byte = flag_byte;
			REGION_PORT:
				read_byte = port_byte;
			default:
				read_byte = `GAP_READ_VALUE;
		endcase
	end

	logic [7:0] rdata_reg;
	wire [7:0] rdata_next = rd_start ? read_byte : rdata_reg;

	// Strobe history makes a held strobe act once
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			rd_seen_reg <= 1'b0;
		else
			rd_seen_reg <= rd_act;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			wr_seen_reg <= 1'b0;
		else
			wr_seen_reg <= wr_act;
	end

	// Low write byte, kept until its high byte
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			stage_reg <= `STAGE_RESET;
		else
			stage_reg <= stage_next;
	end

	// Word copy for the later high-byte read
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			hold_reg <= `WORD_RESET;
		else
			hold_reg <= hold_next;
	end

	// Read byte stands until the next read starts
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			rdata_reg <= `STAGE_RESET;
		else
			rdata_reg <= rdata_next;
	end

	// Last committed command word
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			command_reg <= `WORD_RESET;
		else
			command_reg <= command_next;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			command_valid_reg <= 1'b0;
		else
			command_valid_reg <= cmd_commit;
	end

	// Buffer shared by host and core
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			io_buffer_reg <= `WORD_RESET;
		else
			io_buffer_reg <= io_next;
	end

	// Transmit word and its one-cycle push
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			tx_data_reg <= `WORD_RESET;
		else
			tx_data_reg <= tx_data_next;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			tx_push_reg <= 1'b0;
		else
			tx_push_reg <= tx_commit;
	end

	// Handshake rests high out of reset
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			busy_reg <= 1'b0;
		else
			busy_reg <= busy_next;
	end

	// Per-node storage; no hardware set bits, so only host writes change it
	byte_bank #(.DEPTH(64), .IDX_W(6)) u_node_info (
		.clk(clk),
		.rst(rst),
		.wr_en(wr_node),
		.wr_idx(node_idx),
		.wr_data(wdata_in),
		.set_bits(512'h0),
		.flat(node_info)
	);

	// Core-set error bits; a set beats a host write
	byte_bank #(.DEPTH(8), .IDX_W(3)) u_cyclic_error (
		.clk(clk),
		.rst(rst),
		.wr_en(wr_err),
		.wr_idx(err_idx),
		.wr_data(wdata_in),
		.set_bits(cyclic_error_set),
		.flat(cyclic_error_flags)
	);

	byte_bank #(.DEPTH(32), .IDX_W(5)) u_change_setting (
		.clk(clk),
		.rst(rst),
		.wr_en(wr_set),
		.wr_idx(set_idx),
		.wr_data(wdata_in),
		.set_bits(256'h0),
		.flat(input_change_settings)
	);

	// Core-set change flags, cleared by host writes
	byte_bank #(.DEPTH(32), .IDX_W(5)) u_change_flag (
		.clk(clk),
		.rst(rst),
		.wr_en(wr_flag),
		.wr_idx(flag_idx),
		.wr_data(wdata_in),
		.set_bits(input_change_set),
		.flat(input_change_flags)
	);

	// Four bytes per node, node-major
	byte_bank #(.DEPTH(256), .IDX_W(8)) u_port_data (
		.clk(clk),
		.rst(rst),
		.wr_en(wr_port),
		.wr_idx(port_idx),
		.wr_data(wdata_in),
		.set_bits(2048'h0),
		.flat(port_data)
	);

	assign rdata_out = rdata_reg;
	// Driven only while a read strobe is held
	assign data_oe_n = !rd_act;
	assign command_handshake_out = !busy_reg;
	assign command_word = command_reg;
	assign command_valid = command_valid_reg;
	assign io_buffer = io_buffer_reg;
	assign tx_data = tx_data_reg;
	assign tx_push = tx_push_reg;

endmodule : host_register_map

`default_nettype wire

/* File: verif/core_model.sv */
// Core-side model: finishes commands, supplies receive words, takes transmit words.
// Assumes the map's word ports; slow stalls transmit and runs receive dry.
`default_nettype none

module core_model (
	// Clock, reset, pace
	input wire logic clk, rst, slow,
	// Word side
	input wire logic command_valid, tx_push, rx_pop,
	input wire logic [15:0] tx_data,
	output logic command_done, tx_ready, rx_valid,
	output logic [15:0] rx_data
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [5:0] busy;
	logic [15:0] word, last_tx;
	int n_tx, n_pop;
	assign tx_ready = ~slow;
	assign rx_valid = ~slow;
	// Invalid word shows garbage, not the last value
	assign rx_data = rx_valid ? word : ~word;
	assign command_done = busy == 6'h01;
	always @(posedge clk or posedge rst)
		if (rst)
		begin
			busy <= 6'h00;
			word <= 16'hc300;
			n_tx <= 0;
			n_pop <= 0;
		end
		else
		begin
			if (command_valid)
				busy <= slow ? 6'h28 : 6'h03;
			else if (busy != 6'h00)
				busy <= busy - 6'h01;
			if (tx_push)
				last_tx <= tx_data;
			n_tx <= n_tx + int'(tx_push);
			// Both bytes change so a missed capture shows
			if (rx_pop)
				word <= word + 16'h0101;
			n_pop <= n_pop + int'(rx_pop);
		end
endmodule : core_model

`default_nettype wire

/* File: verif/host_register_map_asserts.sv */
// Port checker for the byte-wide host register map.
// Assumes it is bound onto host_register_map, one clock domain.
`default_nettype none

module host_register_map_asserts (
	// Clock, reset, straps and strobes
	input wire logic clk, rst, host_mode_select_bit0, host_mode_select_bit1,
	input wire logic cs_n, rd_n, wr_n, command_valid, command_done, command_handshake_out,
	input wire logic data_oe_n, tx_push, tx_ready, rx_valid, rx_pop,
	// Buses
	input wire logic [8:0] addr,
	input wire logic [7:0] wdata_in, rdata_out,
	input wire logic [15:0] command_word, tx_data
);
	timeunit 1ns;
	timeprecision 100ps;
	logic wr_q, rd_q;
	wire logic ok = host_mode_select_bit0 & host_mode_select_bit1;
	wire logic wr_on = ok & ~cs_n & ~wr_n;
	wire logic rd_on = ok & ~cs_n & ~rd_n;
	wire logic wr_go = wr_on & ~wr_q;
	wire logic rd_go = rd_on & ~rd_q;
	wire logic cmd_hi = wr_go & (addr == 9'h001);
	wire logic tx_hi = wr_go & (addr == 9'h007);
	// Long strobes act once, so only the first low cycle counts
	always_ff @(posedge clk or posedge rst)
		if (rst)
			{wr_q, rd_q} <= 2'b00;
		else
			{wr_q, rd_q} <= {wr_on, rd_on};
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_oe; data_oe_n == ~rd_on; endproperty
	property p_cmd; cmd_hi |=> command_valid && command_word[15:8] == $past(wdata_in); endproperty
	property p_cmd_src; command_valid |-> $past(cmd_hi); endproperty
	property p_pulse; command_valid |=> !command_valid; endproperty
	property p_hs_low; command_valid |-> !command_handshake_out; endproperty
	property p_hs_high; command_done && !cmd_hi |=> command_handshake_out; endproperty
	property p_tx; tx_hi && tx_ready |=> tx_push && tx_data[15:8] == $past(wdata_in); endproperty
	property p_tx_src; tx_push |-> $past(tx_hi); endproperty
	property p_pop; rx_pop == (rd_go && addr == 9'h006 && rx_valid); endproperty
	property p_gap; rd_go && addr inside {[9'h008:9'h077]} |=> rdata_out == 8'h00; endproperty
	property p_hold; !rd_go |=> $stable(rdata_out); endproperty
	a_oe: assert property (p_oe) else $error("data enable wrong");
	a_cmd: assert property (p_cmd) else $error("command not committed");
	a_cmd_src: assert property (p_cmd_src) else $error("stray command");
	a_pulse: assert property (p_pulse) else $error("command pulse too long");
	a_hs_low: assert property (p_hs_low) else $error("handshake not low");
	a_hs_high: assert property (p_hs_high) else $error("handshake not back");
	a_tx: assert property (p_tx) else $error("transmit word not pushed");
	a_tx_src: assert property (p_tx_src) else $error("stray transmit push");
	a_pop: assert property (p_pop) else $error("receive pop wrong");
	a_gap: assert property (p_gap) else $error("gap read not zero");
	a_hold: assert property (p_hold) else $error("read byte changed");
	c_cmd: cover property (command_valid);
	c_tx: cover property (tx_push);
	c_pop: cover property (rx_pop);
endmodule : host_register_map_asserts

bind host_register_map host_register_map_asserts host_register_map_asserts_inst (.clk, .rst,
	.host_mode_select_bit0, .host_mode_select_bit1, .cs_n, .rd_n, .wr_n, .addr, .wdata_in,
	.rdata_out, .data_oe_n, .command_handshake_out, .command_word, .command_valid,
	.command_done, .tx_data, .tx_push, .tx_ready, .rx_valid, .rx_pop);

`default_nettype wire

/* File: verif/host_register_map_tb_top.sv */
// Self-checking bench for the byte-wide host register map.
// Assumes core_model behind the word ports and the bound port checker.
`default_nettype none

module host_register_map_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0, rst = 1'b1, slow = 1'b0, cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1;
	logic host_mode_select_bit0 = 1'b1, host_mode_select_bit1 = 1'b1;
	logic [8:0] addr = 9'h000;
	logic [7:0] wdata_in = 8'h00, rdata_out, rd;
	logic [15:0] status_word = 16'ha55a, interrupt_status = 16'h3cc3;
	logic [63:0] cyclic_error_set = 64'h0, cyclic_error_flags;
	logic [255:0] input_change_set = 256'h0;
	logic io_load = 1'b0;
	logic [15:0] io_load_data = 16'h0000;
	logic data_oe_n, command_handshake_out, command_valid, command_done;
	logic tx_push, tx_ready, rx_valid, rx_pop;
	logic [15:0] command_word, io_buffer, tx_data, rx_data;
	logic [511:0] node_info;
	logic [255:0] input_change_settings, input_change_flags;
	logic [2047:0] port_data;
	int n_errors = 0, checks_done = 0;
	always #4 clk = ~clk;
	host_register_map host_register_map_inst (.clk, .rst, .host_mode_select_bit0,
		.host_mode_select_bit1, .cs_n, .rd_n, .wr_n, .addr, .wdata_in, .rdata_out,
		.data_oe_n, .command_handshake_out, .command_word, .command_valid, .command_done,
		.status_word, .interrupt_status, .io_buffer, .io_load, .io_load_data,
		.tx_data, .tx_push, .tx_ready, .rx_data, .rx_valid, .rx_pop, .node_info,
		.cyclic_error_set, .cyclic_error_flags, .input_change_settings,
		.input_change_set, .input_change_flags, .port_data);
	core_model core_model_inst (.clk, .rst, .slow, .command_valid, .tx_push, .rx_pop,
		.tx_data, .command_done, .tx_ready, .rx_valid, .rx_data);
	task automatic chk(input string what, input logic [15:0] seen, exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic summarize();
		if (n_errors == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : summarize
	// One byte access; strobes rest high for a cycle before the next
	task automatic acc(input logic w, input logic [8:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		{cs_n, wr_n, rd_n} = {1'b0, ~w, w};
		addr = a;
		wdata_in = d;
		@(posedge clk);
		#1;
		rd = rdata_out;
		{cs_n, wr_n, rd_n} = 3'b111;
	endtask : acc
	task automatic rdc(input logic [8:0] a, input logic [7:0] exp);
		acc(1'b0, a, 8'h00);
		chk($sformatf("byte %h", a), {8'h00, rd}, {8'h00, exp});
	endtask : rdc
	task automatic wait_hs();
		for (int i = 0; i < 100; i++)
		begin
			if (command_handshake_out === 1'b1)
				return;
			@(posedge clk);
			#1;
		end
		chk("handshake wait", 16'h0000, 16'h0001);
		summarize();
	endtask : wait_hs
	task automatic s_cmd();
		chk("idle handshake", {15'h0, command_handshake_out}, 16'h0001);
		acc(1'b1, 9'h000, 8'h34);
		acc(1'b1, 9'h001, 8'h12);
		chk("command", command_word, 16'h1234);
		chk("busy handshake", {15'h0, command_handshake_out}, 16'h0000);
		wait_hs();
		rdc(9'h000, 8'h5a);
		rdc(9'h001, 8'ha5);
		acc(1'b1, 9'h002, 8'hff);
		acc(1'b1, 9'h003, 8'hff);
		rdc(9'h002, 8'hc3);
		rdc(9'h003, 8'h3c);
	endtask : s_cmd
	task automatic s_io();
		acc(1'b1, 9'h004, 8'h78);
		acc(1'b1, 9'h005, 8'h56);
		chk("io buffer", io_buffer, 16'h5678);
		rdc(9'h004, 8'h78);
		rdc(9'h005, 8'h56);
		host_mode_select_bit1 = 1'b0;
		acc(1'b1, 9'h004, 8'hff);
		acc(1'b1, 9'h005, 8'hff);
		host_mode_select_bit1 = 1'b1;
		chk("foreign mode", io_buffer, 16'h5678);
		io_load_data = 16'h9abc;
		io_load = 1'b1;
		@(posedge clk);
		#1;
		io_load = 1'b0;
		chk("core load", io_buffer, 16'h9abc);
		rdc(9'h004, 8'hbc);
		rdc(9'h005, 8'h9a);
	endtask : s_io
	task automatic s_fifo();
		acc(1'b1, 9'h006, 8'hcd);
		acc(1'b1, 9'h007, 8'hab);
		slow = 1'b1;
		acc(1'b1, 9'h006, 8'h11);
		acc(1'b1, 9'h007, 8'h22);
		chk("tx word", core_model_inst.last_tx, 16'habcd);
		chk("tx count", 16'(core_model_inst.n_tx), 16'h0001);
		rdc(9'h006, 8'h00);
		slow = 1'b0;
		rdc(9'h006, 8'h00);
		rdc(9'h007, 8'hc3);
		rdc(9'h006, 8'h01);
		rdc(9'h007, 8'hc4);
		chk("rx pops", 16'(core_model_inst.n_pop), 16'h0002);
	endtask : s_fifo
	task automatic s_gap();
		acc(1'b1, 9'h008, 8'h5a);
		acc(1'b1, 9'h077, 8'h5a);
		rdc(9'h008, 8'h00);
		rdc(9'h077, 8'h00);
		chk("gap side effect", command_word ^ io_buffer, 16'h1234 ^ 16'h9abc);
		acc(1'b1, 9'h004, 8'h11);
		acc(1'b1, 9'h040, 8'h5a);
		acc(1'b1, 9'h003, 8'h5a);
		acc(1'b1, 9'h005, 8'h22);
		chk("gap keeps stage", io_buffer, 16'h2211);
	endtask : s_gap
	task automatic s_areas();
		logic [8:0] t[11] = '{9'h078, 9'h0b7, 9'h0b8, 9'h0bf, 9'h0c0, 9'h0df, 9'h0e0,
			9'h0ff, 9'h100, 9'h1a6, 9'h1ff};
		foreach (t[i])
			acc(1'b1, t[i], t[i][7:0] ^ 8'h3c);
		foreach (t[i])
			rdc(t[i], t[i][7:0] ^ 8'h3c);
		chk("node 0", {8'h00, node_info[7:0]}, 16'h0044);
		chk("node 63", {8'h00, node_info[511:504]}, 16'h008b);
		chk("error byte 7", {8'h00, cyclic_error_flags[63:56]}, 16'h0083);
		chk("setting byte 31", {8'h00, input_change_settings[255:248]}, 16'h00e3);
		chk("flag byte 0", {8'h00, input_change_flags[7:0]}, 16'h00dc);
		chk("port 41 2", {8'h00, port_data[1335:1328]}, 16'h009a);
		chk("port 63 3", {8'h00, port_data[2047:2040]}, 16'h00c3);
		cyclic_error_set = 64'h100;
		input_change_set = 256'h200;
		@(posedge clk);
		#1;
		cyclic_error_set = 64'h0;
		input_change_set = 256'h0;
		rdc(9'h0b9, 8'h01);
		rdc(9'h0e1, 8'h02);
		cyclic_error_set = 64'h1;
		acc(1'b1, 9'h0b8, 8'h00);
		cyclic_error_set = 64'h0;
		rdc(9'h0b8, 8'h01);
	endtask : s_areas
	initial
	begin
		repeat (3) @(posedge clk);
		#1;
		rst = 1'b0;
		s_cmd();
		s_io();
		s_fifo();
		s_gap();
		s_areas();
		summarize();
	end
endmodule : host_register_map_tb_top

`default_nettype wire
